//--- logic/mdw_chan_regs.sv
`default_nettype none
module mdw_chan_regs
   import mdw_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   mdw_wr_if.dst wr,
   input wire logic [5:0] rd_chan_i,
   input wire logic [1:0] rd_dest_i,
   output logic [11:0] rd_word_o
);
   logic [DATA_W-1:0] mem_q [NUM_CH*NUM_DEST];

   function automatic int idx(input logic [5:0] c, input logic [1:0] d);
      return int'(c) * NUM_DEST + int'(d);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // storage; out of range channels are dropped
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         for (int i = 0; i < NUM_CH*NUM_DEST; i++)
            mem_q[i] <= WORD_RST;
      end
      else if (wr.valid && wr.chan <= LAST_CH)
         mem_q[idx(wr.chan, wr.dest)] <= wr.word;
   end

   // readback register for observation
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         rd_word_o <= WORD_RST;
      else if (rd_chan_i <= LAST_CH)
         rd_word_o <= mem_q[idx(rd_chan_i, rd_dest_i)];
      else
         rd_word_o <= WORD_RST;
   end
endmodule
`default_nettype wire

//--- logic/mdw_pkg.sv
`default_nettype none
package mdw_pkg;
   localparam int NUM_CH = 40;
   localparam logic [5:0] LAST_CH = 6'h27;
   localparam logic [5:0] FIRST_CH = 6'h00;
   localparam logic [4:0] ADDR_FIXED = 5'h15;
   localparam logic [7:0] BURST_PTR = 8'hFF;
   localparam int DATA_W = 12;
   localparam int ADDR_W = 6;
   localparam int NUM_DEST = 4;
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic [3:0] ACK_BIT = 4'h8;
   localparam logic [DATA_W-1:0] WORD_RST = 12'h000;
   // serial state machine
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_ADDR = 6'h02,
      ST_PTR  = 6'h04,
      ST_MSB  = 6'h08,
      ST_LSB  = 6'h10,
      ST_SKIP = 6'h20
   } mdw_state_t;
endpackage
`default_nettype wire

//--- logic/mdw_top.sv
`default_nettype none
module mdw_top
   import mdw_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic interface_select_i,
   input wire logic cs_n_i,
   input wire logic wr_n_i,
   input wire logic [5:0] channel_addr_i,
   input wire logic [11:0] parallel_word_i,
   input wire logic dest_select_lo_i,
   input wire logic dest_select_hi_i,
   input wire logic addr_strap_hi_i,
   input wire logic addr_strap_lo_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic toggle_req_i,
   output logic toggle_ok_o,
   output logic burst_active_o,
   output logic [5:0] burst_chan_o,
   input wire logic [5:0] rd_chan_i,
   input wire logic [1:0] rd_dest_i,
   output logic [11:0] rd_word_o
);
   mdw_wr_if wr ();

   logic wr_n_q;
   logic scl_q;
   logic sda_q;
   mdw_state_t st_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q;
   logic burst_q;
   logic [5:0] ptr_q;
   logic [7:0] msb_q;
   logic ack_q;
   logic slot_q;
   logic par_wr;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic [7:0] byte_in;
   logic byte_done;
   logic ser_en;
   logic ser_wr;

   ////////////////////////////////////////////////////////////////////
   // edge history of strobe and two-wire pins
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         wr_n_q <= 1'b1;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         wr_n_q <= wr_n_i;
         scl_q <= scl_i;
         sda_q <= sda_i;
      end
   end

   assign ser_en = interface_select_i;
   // chip select gating, no write otherwise
   assign par_wr = !ser_en && !cs_n_i && !wr_n_q && wr_n_i;

   assign scl_rise = ser_en && !scl_q && scl_i;
   assign scl_fall = ser_en && scl_q && !scl_i;
   assign start_c = ser_en && scl_q && scl_i && sda_q && !sda_i;
   assign stop_c = ser_en && scl_q && scl_i && !sda_q && sda_i;
   assign byte_in = {sh_q[6:0], sda_i};
   // data sampled on clock edge toward ack slot
   assign byte_done = scl_rise && bit_q == LAST_BIT;

   ////////////////////////////////////////////////////////////////////
   // bit counter and shifter; slot_q marks the ninth clock so the ack
   // only moves while the clock is low and never mimics a start or stop
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i || start_c || stop_c)
      begin
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         slot_q <= 1'b0;
      end
      else if (scl_rise && bit_q < ACK_BIT)
      begin
         sh_q <= byte_in;
         bit_q <= bit_q + 4'h1;
      end
      else if (scl_fall && bit_q == ACK_BIT && !slot_q)
         slot_q <= 1'b1;
      else if (scl_fall && slot_q)
      begin
         // ack clock over, next byte starts
         slot_q <= 1'b0;
         bit_q <= 4'h0;
      end
   end

   // byte parser
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         st_q <= ST_IDLE;
         ack_q <= 1'b0;
         msb_q <= 8'h00;
      end
      else if (!ser_en)
      begin
         st_q <= ST_IDLE;
         ack_q <= 1'b0;
      end
      else if (start_c)
      begin
         st_q <= ST_ADDR;
         ack_q <= 1'b0;
      end
      else if (stop_c)
      begin
         st_q <= ST_IDLE;
         ack_q <= 1'b0;
      end
      else if (scl_fall && slot_q)
         ack_q <= 1'b0;
      else if (byte_done)
      begin
         unique case (st_q)
            ST_ADDR:
            begin
               // slave address match, write bit zero
               if (byte_in == {ADDR_FIXED, addr_strap_hi_i,
                               addr_strap_lo_i, 1'b0})
               begin
                  st_q <= ST_PTR;
                  ack_q <= 1'b1;
               end
               else
                  st_q <= ST_SKIP;
            end
            ST_PTR:
            begin
               st_q <= ST_MSB;
               ack_q <= 1'b1;
            end
            ST_MSB:
            begin
               msb_q <= byte_in;
               st_q <= ST_LSB;
               ack_q <= 1'b1;
            end
            ST_LSB:
            begin
               ack_q <= 1'b1;
               if (burst_q && ptr_q != LAST_CH)
                  st_q <= ST_MSB;
               else
                  st_q <= ST_PTR;
            end
            ST_IDLE, ST_SKIP:
               st_q <= st_q;
         endcase
      end
   end

   // burst mode and channel pointer
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i || !ser_en || stop_c)
      begin
         burst_q <= 1'b0;
         ptr_q <= FIRST_CH;
      end
      else if (byte_done && st_q == ST_PTR)
      begin
         // 0xFF enters burst, start at channel zero
         burst_q <= byte_in == BURST_PTR;
         ptr_q <= byte_in == BURST_PTR ? FIRST_CH : byte_in[5:0];
      end
      else if (byte_done && st_q == ST_LSB && burst_q)
      begin
         if (ptr_q == LAST_CH)
            burst_q <= 1'b0;
         else
            ptr_q <= ptr_q + 6'h01;
      end
   end

   assign ser_wr = byte_done && st_q == ST_LSB;

   ////////////////////////////////////////////////////////////////////
   // write request mux; serial held off while parallel selected
   always_comb
   begin
      wr.valid = par_wr || ser_wr;
      if (par_wr)
      begin
         // latch address and data, 6-bit channel
         wr.chan = channel_addr_i;
         wr.dest = {dest_select_hi_i, dest_select_lo_i};
         wr.word = parallel_word_i;
      end
      else
      begin
         // select bits from first data byte
         wr.chan = ptr_q;
         wr.dest = msb_q[7:6];
         wr.word = {msb_q[3:0], byte_in};
      end
   end

   mdw_chan_regs u_regs (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .wr(wr),
      .rd_chan_i(rd_chan_i),
      .rd_dest_i(rd_dest_i),
      .rd_word_o(rd_word_o)
   );

   // ack pulls data low; open drain so value is always zero
   assign sda_o = 1'b0;
   // driven only inside the ninth clock slot
   assign sda_oe_o = ack_q && slot_q;
   assign toggle_ok_o = toggle_req_i && !burst_q;
   assign burst_active_o = burst_q;
   assign burst_chan_o = ptr_q;
endmodule
`default_nettype wire

//--- logic/mdw_wr_if.sv
`default_nettype none
// channel write request shared by both write paths
interface mdw_wr_if;
   logic valid;
   logic [5:0] chan;
   logic [1:0] dest;
   logic [11:0] word;
   modport src (output valid, output chan, output dest, output word);
   modport dst (input valid, input chan, input dest, input word);
endinterface
`default_nettype wire

//--- verification/mdw_checker.sv
`default_nettype none
module mdw_checker
   import mdw_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic interface_select_i,
   input wire logic cs_n_i,
   input wire logic wr_n_i,
   input wire logic [5:0] channel_addr_i,
   input wire logic [11:0] parallel_word_i,
   input wire logic dest_select_lo_i,
   input wire logic dest_select_hi_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic toggle_req_i,
   input wire logic toggle_ok_o,
   input wire logic burst_active_o,
   input wire logic [5:0] burst_chan_o,
   input wire logic [5:0] rd_chan_i,
   input wire logic [1:0] rd_dest_i,
   input wire logic [11:0] rd_word_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // accepted strobe with the read port aimed at its target
   sequence s_par_wr;
      $rose(wr_n_i) && !cs_n_i && !interface_select_i
      && channel_addr_i < 6'h28 && rd_chan_i == channel_addr_i
      && rd_dest_i == {dest_select_hi_i, dest_select_lo_i};
   endsequence
   sequence s_rd_held;
      $stable(rd_chan_i) && $stable(rd_dest_i);
   endsequence
   AST_PAR_WRITE: assert property (s_par_wr ##1 s_rd_held |=>
      rd_word_o == $past(parallel_word_i, 2))
      else $error("parallel word not stored");
   AST_TOGGLE: assert property (
      toggle_ok_o == (toggle_req_i && !burst_active_o))
      else $error("toggle honoured in burst");
   AST_PTR_RANGE: assert property (
      burst_active_o |-> burst_chan_o <= LAST_CH)
      else $error("burst pointer out of range");
   AST_PAR_QUIET: assert property (
      !interface_select_i && $past(!interface_select_i) |-> !sda_oe_o)
      else $error("serial answers in parallel mode");
   AST_ACK_LOW: assert property (
      sda_oe_o |-> !sda_o)
      else $error("ack does not pull low");
   AST_STOP: assert property (
      $rose(sda_i) && scl_i && $past(scl_i) |-> ##[1:6] !burst_active_o)
      else $error("stop left burst on");
   AST_BURST_START: assert property (
      $rose(burst_active_o) |-> burst_chan_o == FIRST_CH)
      else $error("burst not at first channel");
   AST_PTR_STEP: assert property (
      burst_active_o && $past(burst_active_o) && $changed(burst_chan_o)
      |-> burst_chan_o == $past(burst_chan_o) + 6'h01)
      else $error("burst pointer skipped");
   AST_ACK_SCL_LOW: assert property (
      $changed(sda_oe_o) |-> !scl_i)
      else $error("ack moved while clock high");
endmodule
bind mdw_top mdw_checker u_chk (.*);
`default_nettype wire

//--- verification/mdw_host_model.sv
`default_nettype none
module mdw_host_model (
   input wire logic clk_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   output logic scl_o,
   output logic sda_line_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic pull_q = 1'b0;
   // open-drain data line with pull-up
   assign sda_line_o = !(pull_q || (sda_oe_o && !sda_o));
   initial scl_o = 1'b1;
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // data moves only while the clock is low
   task automatic clk_bit(input logic b, output logic seen);
      pull_q = !b;
      tick(8);
      scl_o = 1'b1;
      tick(4);
      seen = sda_line_o;
      tick(4);
      scl_o = 1'b0;
      tick(2);
   endtask
   task automatic send_byte(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         clk_bit(v[i], s);
      clk_bit(1'b1, s);
      ack = !s;
   endtask
   task automatic start_c;
      scl_o = 1'b1;
      tick(4);
      pull_q = 1'b1;
      tick(4);
      scl_o = 1'b0;
      tick(2);
   endtask
   task automatic stop_c;
      pull_q = 1'b1;
      tick(4);
      scl_o = 1'b1;
      tick(4);
      pull_q = 1'b0;
      tick(8);
   endtask
endmodule
`default_nettype wire

//--- verification/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import mdw_pkg::*;
   logic clk_i = 0, sys_rst_i = 1, isel = 1, cs_n = 1, wr_n = 1, tog = 0;
   logic [5:0] addr = 0, rd_chan = 0, bch;
   logic [1:0] dest = 0, strap = 2'h2, rd_dest = 0;
   logic [11:0] word = 0, rdw;
   logic scl, sda, sda_o, sda_oe, tok, bact;
   logic [31:0] seed = 32'h9E2BFD4B;
   int errors = 0, check_count = 0;
   int exp_m [40][4];
   initial forever #25 clk_i = ~clk_i;
   mdw_top u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .interface_select_i(isel), .cs_n_i(cs_n), .wr_n_i(wr_n),
      .channel_addr_i(addr), .parallel_word_i(word),
      .dest_select_lo_i(dest[0]), .dest_select_hi_i(dest[1]),
      .addr_strap_hi_i(strap[1]), .addr_strap_lo_i(strap[0]),
      .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
      .toggle_req_i(tog), .toggle_ok_o(tok), .burst_active_o(bact),
      .burst_chan_o(bch), .rd_chan_i(rd_chan), .rd_dest_i(rd_dest),
      .rd_word_o(rdw));
   mdw_host_model u_host (.clk_i(clk_i), .sda_o(sda_o),
      .sda_oe_o(sda_oe), .scl_o(scl), .sda_line_o(sda));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input string n, input logic [11:0] s, e);
      check_count++;
      if (s !== e)
      begin
         errors++;
         $display("MISMATCH %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic finish_test;
      if (errors == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic par_wr(input logic [5:0] a, input logic [1:0] d,
      input logic [11:0] w, input logic c, s);
      @(posedge clk_i);
      #1;
      {cs_n, isel, wr_n, addr, dest, word} = {c, s, 1'b0, a, d, w};
      {rd_chan, rd_dest} = {a, d};
      @(posedge clk_i);
      #1;
      wr_n = 1;
      @(posedge clk_i);
      #1;
      {cs_n, isel} = 2'b11;
      if (!c && !s && a < 40)
         exp_m[a][d] = w;
   endtask
   task automatic chk_all;
      for (int c = 0; c < 40; c++)
         for (int d = 0; d < 4; d++)
         begin
            {rd_chan, rd_dest} = {6'(c), 2'(d)};
            repeat (2) @(posedge clk_i);
            #1;
            check("rd_word_o", rdw, 12'(exp_m[c][d]));
         end
   endtask
   task automatic sbyte(input logic [7:0] v, input logic ea);
      logic a;
      u_host.send_byte(v, a);
      check("ack", a, ea);
   endtask
   task automatic sdata(input int c, input logic [1:0] d, logic [11:0] w);
      sbyte({d, 2'b00, w[11:8]}, 1);
      sbyte(w[7:0], 1);
      exp_m[c][d] = w;
   endtask
   initial
   begin
      repeat (60000) @(posedge clk_i);
      errors++;
      finish_test();
   end
   initial
   begin
      repeat (5) @(posedge clk_i);
      #1;
      sys_rst_i = 0;
      chk_all();
      for (int i = 0; i < 48; i++)
      begin
         seed = lfsr(seed);
         tog = seed[22];
         par_wr(seed[5:0], seed[7:6], seed[19:8], &seed[21:20], i % 8 == 7);
      end
      chk_all();
      tog = 1;
      u_host.start_c();
      sbyte({ADDR_FIXED, 2'h1, 1'b0}, 0);
      u_host.start_c();
      sbyte({ADDR_FIXED, strap, 1'b1}, 0);
      u_host.start_c();
      sbyte({ADDR_FIXED, strap, 1'b0}, 1);
      sbyte(8'h05, 1);
      sdata(5, 2'h3, 12'hA5C);
      sbyte(8'h27, 1);
      sdata(39, 2'h1, 12'h3F1);
      sbyte(BURST_PTR, 1);
      for (int c = 0; c < 40; c++)
      begin
         seed = lfsr(seed);
         sdata(c, seed[1:0], seed[13:2]);
         check("burst", bact, c != 39);
         if (c != 39)
            check("ptr", bch, 12'(c + 1));
      end
      sbyte(8'h02, 1);
      sdata(2, 2'h0, 12'h123);
      sbyte(BURST_PTR, 1);
      for (int c = 0; c < 3; c++)
         sdata(c, 2'(c), 12'(c * 291));
      u_host.stop_c();
      check("burst", bact, 0);
      isel = 0;
      u_host.start_c();
      sbyte({ADDR_FIXED, strap, 1'b0}, 0);
      u_host.stop_c();
      isel = 1;
      chk_all();
      finish_test();
   end
endmodule
`default_nettype wire
